// File: rtl/imv_pkg.sv
// package of constants for the interrupt mask and vector unit
package imv_pkg;
  // source count split over the two register groups
  localparam int unsigned NUM_SRC  = 14;
  localparam int unsigned GRP_ONE  = 8;
  localparam int unsigned GRP_TWO  = 6;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLEAR_ONE  = 8'hda;
  localparam logic [7:0] IDX_CLEAR_TWO  = 8'hdc;
  localparam logic [7:0] IDX_MASK_TWO   = 8'hde;
  localparam logic [7:0] IDX_MASK_ONE   = 8'hdf;
  localparam logic [7:0] IDX_SW_EN      = 8'he1;
  localparam logic [7:0] IDX_VECTOR     = 8'he2;
  localparam logic [7:0] IDX_EVT_STATUS = 8'he4;
  localparam logic [7:0] IDX_EVT_MASK   = 8'he5;
  // field positions
  localparam int unsigned SOFT_POST_ENABLE_BIT = 0;
  localparam int unsigned EVT_POSTED           = 0;
  localparam int unsigned EVT_CLEAR_ALL        = 1;
  localparam int unsigned EVT_SERVICED         = 2;
  localparam int unsigned NUM_EVT              = 3;
  // reset values
  localparam logic [7:0] RST_MASK_ONE  = 8'h00;
  localparam logic [5:0] RST_MASK_TWO  = 6'h00;
  localparam logic       RST_SW_EN     = 1'b0;
  localparam logic [13:0] RST_POSTED   = 14'h0000;
  localparam logic [2:0] RST_EVT       = 3'h0;
  // vector byte returned when nothing is pending
  localparam logic [7:0] VEC_NONE      = 8'h00;
  // vector low bytes, source 0 first; source 0 has the highest priority
  localparam logic [7:0] VEC_BASE      = 8'h20;
  localparam logic [7:0] VEC_STEP      = 8'h04;
  // axi response codes
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;
endpackage : imv_pkg

// File: rtl/imv_unit.sv
// interrupt mask, soft post and vector readout unit with axi4-lite registers
`timescale 1ns/1ps

// Contract
// RULE1 - a masked source still records its posted interrupt
// RULE2 - usb/timer mask register, read/write, reset zero, eight source masks
// RULE3 - second mask register, reset zero, wakeup at bit 5, endpoints 8-4 below
// RULE4 - mask one lets a posted interrupt become pending; zero masks it
// RULE5 - soft enable register holds one bit at 0, reset zero
// RULE6 - soft enable bit is no mask; it only changes clear-register writes
// RULE7 - vector read returns low byte of highest-priority pending vector
// RULE8 - vector read returns zero when nothing is pending
// RULE9 - core service removes the reported highest-priority interrupt; code removes the live top, one cycle ahead of the reported vector
// RULE10 - any vector write clears all posted and pending, driving clear lines
// RULE11 - soft enable zero: writing zero to a clear bit clears posted
// RULE12 - soft enable one: writing one to a clear bit posts interrupt
// RULE13 - a higher-priority pending interrupt is presented to the core first
// RULE14 - second mask bits 7 and 6 read zero and ignore writes
// RULE15 - reading the vector has no effect on posted or pending state
module imv_unit
#(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // axi4-lite write address
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  // axi4-lite write data
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // axi4-lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // axi4-lite read address
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [ADDR_W-1:0]            s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  // axi4-lite read data
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // interrupt sources
  input  wire logic [imv_pkg::NUM_SRC-1:0]  src_post,
  output logic [imv_pkg::NUM_SRC-1:0]       src_clear,
  // processor core side
  output logic                              core_irq_req,
  output logic [7:0]                        core_irq_vector,
  input  wire logic                         core_irq_ack,
  // block event interrupt
  output logic                              irq
);
  import imv_pkg::*;

  // elaboration checks: the decode uses bits 9:2 as the word index, so the
  // address must hold them; the source table must fill both register groups
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
    $error("imv_unit: ADDR_W must lie between 10 and 32");
  end
  if (NUM_SRC != GRP_ONE + GRP_TWO || GRP_ONE != 8 || GRP_TWO > 8) begin : g_bad_groups
    $error("imv_unit: source groups do not fit the clear and mask registers");
  end

  // register state
  logic [7:0]          usb_timer_mask;
  logic [5:0]          usb_wake_endpoint_high_mask;
  logic                soft_post_enable_bit;
  logic [NUM_SRC-1:0]  posted;
  logic [NUM_EVT-1:0]  evt_status;
  logic [NUM_EVT-1:0]  evt_mask;

  // bus holding state
  logic                aw_full;
  logic                w_full;
  logic [ADDR_W-1:0]   aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic [31:0]         next_rdata;
  logic [1:0]          next_rresp;

  // write channels are taken in either order and held until the response
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // handshake strobes for the cycle at hand
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire ar_take  = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_full && w_full && !s_axi_bvalid;

  // address decode: word index, upper bits must be zero
  wire [7:0] wr_idx   = aw_addr[9:2];
  wire [7:0] rd_idx   = s_axi_araddr[9:2];
  wire       wr_upper = (ADDR_W > 10) ? (aw_addr >> 10) == '0 : 1'b1;
  wire       rd_upper = (ADDR_W > 10) ? (s_axi_araddr >> 10) == '0 : 1'b1;
  wire       wr_lane0 = do_write && w_strb[0];
  wire [7:0] wbyte    = w_data[7:0];

  // write strobes: lane 0 only, since every register is one byte wide
  wire wr_mask_one  = wr_lane0 && wr_upper && (wr_idx == IDX_MASK_ONE);
  wire wr_mask_two  = wr_lane0 && wr_upper && (wr_idx == IDX_MASK_TWO);
  wire wr_sw_en     = wr_lane0 && wr_upper && (wr_idx == IDX_SW_EN);
  wire wr_vector    = wr_lane0 && wr_upper && (wr_idx == IDX_VECTOR);
  wire wr_clear_one = wr_lane0 && wr_upper && (wr_idx == IDX_CLEAR_ONE);
  wire wr_clear_two = wr_lane0 && wr_upper && (wr_idx == IDX_CLEAR_TWO);
  wire wr_evt_stat  = wr_lane0 && wr_upper && (wr_idx == IDX_EVT_STATUS);
  wire wr_evt_mask  = wr_lane0 && wr_upper && (wr_idx == IDX_EVT_MASK);
  wire wr_hit       = wr_upper && (wr_idx == IDX_MASK_ONE || wr_idx == IDX_MASK_TWO ||
                      wr_idx == IDX_SW_EN || wr_idx == IDX_VECTOR ||
                      wr_idx == IDX_CLEAR_ONE || wr_idx == IDX_CLEAR_TWO ||
                      wr_idx == IDX_EVT_STATUS || wr_idx == IDX_EVT_MASK);

  // pending set: the mask only gates promotion, posting goes on regardless
  wire [NUM_SRC-1:0] src_mask = {usb_wake_endpoint_high_mask, usb_timer_mask}; // RULE2 RULE3
  wire [NUM_SRC-1:0] pending  = posted & src_mask;          // RULE1 RULE4

  // priority chain: lowest index wins, so a newer higher source overtakes an
  // older lower one; the chain is fully combinational and settles each cycle
  wire [NUM_SRC:0]    above_busy;                          // a higher source is pending
  wire [NUM_SRC-1:0]  top_onehot;
  wire [7:0]          top_vector;
  wire [7:0]          vec_chain [0:NUM_SRC];
  assign above_busy[0] = 1'b0;
  assign vec_chain[0]  = VEC_NONE;                          // RULE8
  for (genvar s = 0; s < NUM_SRC; s = s + 1) begin : g_prio
    // each source owns a fixed vector from its place in the table
    wire [7:0] own_vec = 8'(VEC_BASE + 8'(s) * VEC_STEP);
    assign top_onehot[s]   = pending[s] && !above_busy[s];  // RULE13
    assign above_busy[s+1] = above_busy[s] || pending[s];
    assign vec_chain[s+1]  = top_onehot[s] ? own_vec : vec_chain[s]; // RULE7
  end
  assign top_vector = vec_chain[NUM_SRC];

  // clear register writes: meaning of each bit set by the soft enable bit
  wire [NUM_SRC-1:0] clr_wdata = {wbyte[GRP_TWO-1:0], wbyte};
  wire [NUM_SRC-1:0] clr_sel   = {{GRP_TWO{wr_clear_two}}, {GRP_ONE{wr_clear_one}}};
  wire [NUM_SRC-1:0] sw_post   = soft_post_enable_bit ? (clr_sel & clr_wdata)
                                                      : '0;  // RULE12 RULE6
  wire [NUM_SRC-1:0] sw_clear  = soft_post_enable_bit ? '0
                                                      : (clr_sel & ~clr_wdata); // RULE11 RULE6

  // service removes only the top interrupt of the live chain; the reported vector lags it by one cycle
  wire [NUM_SRC-1:0] svc_clear = core_irq_ack ? top_onehot : '0;  // RULE9

  // a source post in the same cycle as any clear survives: set beats clear
  wire [NUM_SRC-1:0] all_clear   = wr_vector ? '1 : (sw_clear | svc_clear); // RULE10
  wire [NUM_SRC-1:0] next_posted = (posted & ~all_clear) | src_post | sw_post;

  // block events for the system interrupt
  wire [NUM_EVT-1:0] evt_set = {core_irq_ack && (pending != '0), wr_vector,
                                (src_post | sw_post) != '0};
  wire [NUM_EVT-1:0] evt_clr = wr_evt_stat ? wbyte[NUM_EVT-1:0] : '0;
  wire [NUM_EVT-1:0] next_evt_status = (evt_status & ~evt_clr) | evt_set;

  // mask and soft enable registers; only byte lane 0 carries meaning
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_timer_mask              <= RST_MASK_ONE;
      usb_wake_endpoint_high_mask <= RST_MASK_TWO;
      soft_post_enable_bit        <= RST_SW_EN;
    end else begin
      if (wr_mask_one) usb_timer_mask <= wbyte;                          // RULE2
      if (wr_mask_two) usb_wake_endpoint_high_mask <= wbyte[GRP_TWO-1:0]; // RULE3 RULE14
      if (wr_sw_en) soft_post_enable_bit <= wbyte[SOFT_POST_ENABLE_BIT];  // RULE5
    end
  end

  // one posted flag per source; reads of any register never touch these,
  // so only posts, clear writes, vector writes and service change them
  for (genvar s = 0; s < NUM_SRC; s = s + 1) begin : g_posted
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        posted[s] <= RST_POSTED[s];
      end else begin
        posted[s] <= next_posted[s];                        // RULE15
      end
    end
  end

  // block event status and its mask; a new event beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status <= RST_EVT;
      evt_mask   <= RST_EVT;
    end else begin
      if (wr_evt_mask) evt_mask <= wbyte[NUM_EVT-1:0];
      evt_status <= next_evt_status;
    end
  end

  // the request lags the posted state by one cycle, so a core that acks on a
  // stale request after the last source went away simply clears nothing
  // core outputs and clear lines; clear lines pulse one cycle after the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_irq_req    <= 1'b0;
      core_irq_vector <= VEC_NONE;
      src_clear       <= '0;
      irq             <= 1'b0;
    end else begin
      core_irq_req    <= above_busy[NUM_SRC];               // any unmasked post
      core_irq_vector <= top_vector;                        // RULE7 RULE13
      src_clear       <= wr_vector ? '1 : '0;               // RULE10
      irq             <= (next_evt_status & evt_mask) != '0;
    end
  end

  // read mux; vector read is side-effect free
  wire rd_hit = rd_upper && (rd_idx == IDX_MASK_ONE || rd_idx == IDX_MASK_TWO ||
                rd_idx == IDX_SW_EN || rd_idx == IDX_VECTOR ||
                rd_idx == IDX_CLEAR_ONE || rd_idx == IDX_CLEAR_TWO ||
                rd_idx == IDX_EVT_STATUS || rd_idx == IDX_EVT_MASK);
  // read decode; the vector arm is a plain look at the live chain, so a
  // read never consumes an interrupt
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx == IDX_MASK_ONE) begin
      rd_byte = usb_timer_mask;                             // RULE2
    end else if (rd_idx == IDX_MASK_TWO) begin
      rd_byte = {2'b00, usb_wake_endpoint_high_mask};       // RULE14
    end else if (rd_idx == IDX_SW_EN) begin
      rd_byte = {7'h00, soft_post_enable_bit};              // RULE5
    end else if (rd_idx == IDX_VECTOR) begin
      rd_byte = top_vector;                                 // RULE7 RULE8 RULE15
    end else if (rd_idx == IDX_CLEAR_ONE) begin
      rd_byte = posted[GRP_ONE-1:0];
    end else if (rd_idx == IDX_CLEAR_TWO) begin
      rd_byte = {2'b00, posted[NUM_SRC-1:GRP_ONE]};
    end else if (rd_idx == IDX_EVT_STATUS) begin
      rd_byte = {5'h00, evt_status};
    end else if (rd_idx == IDX_EVT_MASK) begin
      rd_byte = {5'h00, evt_mask};
    end
  end
  // unmapped words read zero and answer slverr
  assign next_rdata = rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
  assign next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;

  // write channel holding registers; the write waits for both halves, so the
  // address and the data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (w_take) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  // write response; unmapped word answers slverr and changes nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data channel, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : imv_unit

// File: bench/imv_unit_props.sv
// assertion checker for the interrupt mask and vector unit
`timescale 1ns/1ps
module imv_unit_props (
  // clock and reset
  input wire logic                        aclk,
  input wire logic                        aresetn,
  // register bus
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wready,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic [31:0]                 s_axi_rdata,
  // interrupt side
  input wire logic [imv_pkg::NUM_SRC-1:0] src_clear,
  input wire logic                        core_irq_req,
  input wire logic [7:0]                  core_irq_vector
);
  import imv_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a vector write drives all clear lines together, for one cycle only
  clr_all_pulse_a: assert property (src_clear != 0 |-> src_clear == '1 ##1 src_clear == 0)
    else $error("clear lines not one all-ones pulse");
  idle_vec_zero_a: assert property (!core_irq_req |-> core_irq_vector == VEC_NONE)
    else $error("vector not zero while idle");
  req_vec_range_a: assert property (core_irq_req |-> core_irq_vector[1:0] == 2'b00
    && core_irq_vector >= VEC_BASE && core_irq_vector <= VEC_BASE + VEC_STEP * 8'h0d)
    else $error("vector outside source table");
  // bus answers stand until taken; new requests wait for the answer
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : imv_unit_props

bind imv_unit imv_unit_props u_props (.*);

// File: bench/imv_core_model.sv
// processor core model: acknowledges a held request after lat cycles
`timescale 1ns/1ps
module imv_core_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // request side
  input  wire logic       req,
  input  wire logic       go,
  input  wire logic [2:0] lat,
  output logic            ack
);
  logic [2:0] wait_cnt;
  logic       want;
  assign want = go && req && !ack;  // never acks twice in a row, req lags the ack
  // count while wanting, pulse ack once the delay is reached
  always_ff @(posedge aclk) begin
    ack      <= aresetn && want && wait_cnt >= lat;
    wait_cnt <= (aresetn && want && wait_cnt < lat) ? wait_cnt + 3'h1 : 3'h0;
  end
endmodule : imv_core_model

// File: bench/tb_interrupt_mask_vector_unit.sv
// self-checking bench for the interrupt mask and vector unit
`timescale 1ns/1ps
module tb_interrupt_mask_vector_unit;
  import imv_pkg::*;
  logic        aclk = 0, aresetn = 0, go = 0, core_irq_ack, core_irq_req, irq;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_bvalid;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0, lat = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wq[$];
  logic [13:0] src_post = 0, src_clear, cq[$];
  logic [7:0]  core_irq_vector;
  logic [8:0]  vq[$];
  logic [33:0] rq[$];
  int          error_cnt = 0, n_tests = 0, seed = 68;
  always #5 aclk = ~aclk;
  imv_unit dut (.*);
  imv_core_model u_core (.aclk(aclk), .aresetn(aresetn), .req(core_irq_req), .go(go),
                         .lat(lat), .ack(core_irq_ack));
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] vec(input logic [7:0] i);
    return VEC_BASE + VEC_STEP * i;
  endfunction : vec
  // write: address and data offered together, response taken after a random stall
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wq.push_back(RESP_OKAY);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_awvalid || s_axi_wvalid);
    repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, 24'h0, d});
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask : rd
  task automatic post(input logic [13:0] v);
    src_post <= v;
    @(posedge aclk);
    src_post <= 0;
    @(posedge aclk);
  endtask : post
  task automatic serve(input logic [2:0] l, input logic [7:0] v);
    vq.push_back({1'b1, v});
    lat <= l;
    go <= 1;
    do @(posedge aclk); while (!core_irq_ack);
    go <= 0;
  endtask : serve
  task automatic wait_irq(input logic v);
    for (int i = 0; i < 20 && irq !== v; i++) @(posedge aclk);
    chk({33'h0, irq}, {33'h0, v});
  endtask : wait_irq
  task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // watcher: every completed response is compared with the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, {wq.pop_front(), 32'h0});
    if (core_irq_ack) chk({25'h0, core_irq_req, core_irq_vector}, {25'h0, vq.pop_front()});
    if (aresetn && src_clear !== 14'h0) chk({20'h0, src_clear}, {20'h0, cq.pop_front()});
  end
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #50us;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(IDX_MASK_ONE, 8'h00);
    rd(IDX_MASK_TWO, 8'h00);
    rd(IDX_SW_EN, 8'h00);
    rd(IDX_VECTOR, VEC_NONE);
    wr(IDX_MASK_TWO, 8'hff);
    rd(IDX_MASK_TWO, 8'h3f);
    wr(IDX_MASK_ONE, 8'hff);
    rd(IDX_MASK_ONE, 8'hff);
    post(14'h0224);
    rd(IDX_VECTOR, vec(2));
    serve(3'h0, vec(2));
    rd(IDX_VECTOR, vec(5));
    rd(IDX_VECTOR, vec(5));
    serve(3'h5, vec(5));
    rd(IDX_VECTOR, vec(9));
    serve(3'h2, vec(9));
    rd(IDX_VECTOR, VEC_NONE);
    wr(IDX_MASK_ONE, 8'h00);
    post(14'h0020);
    rd(IDX_VECTOR, VEC_NONE);
    rd(IDX_CLEAR_ONE, 8'h20);
    wr(IDX_MASK_ONE, 8'hff);
    rd(IDX_VECTOR, vec(5));
    post(14'h0002);
    serve(3'h3, vec(1));
    wr(IDX_CLEAR_ONE, 8'hdf);
    rd(IDX_CLEAR_ONE, 8'h00);
    post(14'h0200);
    wr(IDX_SW_EN, 8'h01);
    rd(IDX_SW_EN, 8'h01);
    wr(IDX_CLEAR_TWO, 8'h20);
    rd(IDX_CLEAR_TWO, 8'h22);
    rd(IDX_VECTOR, vec(9));
    cq.push_back(14'h3fff);
    wr(IDX_VECTOR, 8'($random(seed)));
    rd(IDX_CLEAR_TWO, 8'h00);
    rd(IDX_VECTOR, VEC_NONE);
    chk(34'(cq.size()), 34'h0);
    rd(8'h00, 8'h00, RESP_SLVERR);
    wr(IDX_EVT_MASK, 8'h07);
    wait_irq(1'b1);
    wr(IDX_EVT_STATUS, 8'h07);
    wait_irq(1'b0);
    wr(IDX_EVT_MASK, 8'h00);
    post(14'h0001);
    rd(IDX_EVT_STATUS, 8'h01);
    wait_irq(1'b0);
    stop_test();
  end
endmodule : tb_interrupt_mask_vector_unit
